// ---- design/cssc_ctrl.sv ----
// Purpose: subsystem control bits 26..6 and the logic they steer
// Assumes: all event inputs are on clk_sys; primitive path is 64 bits
// Notes:   every output is registered; bus answers after one wait cycle
`timescale 1ns/1ns
module cssc_ctrl #(
  parameter int XW = 16
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  // avalon-mm slave
  input  wire logic [3:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // memory escalation
  input  wire cssc_pkg::cssc_mem_type cm_in,
  input  wire cssc_pkg::cssc_mem_type pm_in,
  output logic                        cm_high_pri,
  output logic                        pm_high_pri,
  // lock, buffers, reset, status, ack, timers
  input  wire logic                   mem_error,
  output logic                        arb_lock,
  output logic                        pci_wbuf_bypass,
  output logic                        pm_wbuf_bypass,
  output logic                        cm_wbuf_bypass,
  input  wire logic                   pseudo_reset,
  output logic                        master_idle,
  input  wire logic [7:0]             err_status_in,
  input  wire logic [7:0]             event_status_in,
  output logic [7:0]                  event_status,
  input  wire logic                   hang_detect,
  output logic                        auto_ack,
  output logic                        deadman_disable,
  input  wire logic                   dma_vm_err,
  input  wire logic                   dc_vm_err,
  input  wire logic                   mem_locked,
  input  wire logic                   serial_rx_irq,
  output cssc_pkg::cssc_irq_type      irq_out,
  // device control primitive launch
  output logic                        prim_launch,
  output logic [63:0]                 prim_data
);
  import cssc_pkg::*;

  logic [31:0]    ctrl_r, ctrl_nxt;          // control fields
  logic [XW-1:0]  xover_r, xover_nxt;        // crossover value
  logic [7:0]     err_r, err_nxt;            // test-port error status
  logic [7:0]     ev_r, ev_nxt;              // core event status
  logic [31:0]    upper_r, upper_nxt;        // held upper primitive half
  logic           half_r, half_nxt;          // upper half received
  logic           wait_r, wait_nxt;          // waitrequest register
  logic [31:0]    rd_r, rd_nxt;              // read data register
  logic           lock_r, lock_nxt;          // arbiter lock
  logic           cmh_r, cmh_nxt;
  logic           pmh_r, pmh_nxt;
  logic           idle_r, idle_nxt;
  logic           aack_r, aack_nxt;
  logic           launch_r, launch_nxt;
  logic [63:0]    pdata_r, pdata_nxt;
  cssc_irq_type   irq_r, irq_nxt;
  logic [31:0]    xo_m;                       // merged crossover write word

  // byte-lane merge, used for the control and crossover registers
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // escalation for one memory; drops as soon as the trigger is gone
  function automatic logic esc(input logic hi, input logic lat_en, input logic full_en,
                               input cssc_mem_type m, input logic [XW-1:0] xv);
    logic r;
    r = hi;
    if (lat_en && (m.lat_cnt[XW-1:0] > xv)) begin
      r = 1'b1;
    end
    if (full_en && m.wbuf_full) begin
      r = 1'b1;
    end
    return r & m.req;
  endfunction

  // bus and register next state; one wait cycle then a single-cycle answer
  always_comb begin
    ctrl_nxt   = ctrl_r;
    xover_nxt  = xover_r;
    upper_nxt  = upper_r;
    half_nxt   = half_r;
    launch_nxt = 1'b0;
    pdata_nxt  = pdata_r;
    rd_nxt     = rd_r;
    wait_nxt   = 1'b1;
    xo_m       = 32'h0000_0000;
    if ((avs_read || avs_write) && wait_r) begin
      wait_nxt = 1'b0;                 // answer on the next edge
      if (avs_read) begin
        case (avs_address)
          CSSC_OFS_CTRL:   rd_nxt = ctrl_r;
          CSSC_OFS_XOVER:  rd_nxt = {{(32-XW){1'b0}}, xover_r};
          CSSC_OFS_STATUS: rd_nxt = {8'h00, ev_r, err_r, 7'h00, lock_r};
          CSSC_OFS_PRIM:   rd_nxt = pdata_r[31:0];
          default:         rd_nxt = CSSC_UNMAPPED_DATA;
        endcase
      end
    end
    // a write lands only at the edge where the master sees waitrequest low,
    // so software and the steered logic never see the new value early
    if (avs_write && !wait_r) begin
        case (avs_address)
          CSSC_OFS_CTRL: begin
            ctrl_nxt = be_merge(ctrl_r, avs_writedata, avs_byteenable) & CSSC_CTRL_MASK;
          end
          CSSC_OFS_XOVER: begin
            xo_m      = be_merge({{(32-XW){1'b0}}, xover_r}, avs_writedata,
                                 avs_byteenable);
            xover_nxt = xo_m[XW-1:0];
          end
          CSSC_OFS_PRIM: begin
            if (!ctrl_r[CSSC_B_PRIM64]) begin
              launch_nxt = 1'b1;                                     // 32-bit mode
              pdata_nxt  = {32'h0000_0000, avs_writedata};
              half_nxt   = 1'b0;
            end else if (!half_r) begin
              upper_nxt = avs_writedata;
              half_nxt  = 1'b1;
            end else begin
              launch_nxt = 1'b1;
              pdata_nxt  = {upper_r, avs_writedata};
              half_nxt   = 1'b0;
            end
          end
          default: begin
            rd_nxt = rd_r;                     // unmapped write ignored
          end
        endcase
    end
  end

  // steered logic next state
  always_comb begin
    cmh_nxt  = esc(ctrl_r[CSSC_B_CM_HI], ctrl_r[CSSC_B_CM_LAT], ctrl_r[CSSC_B_CM_FULL],
                   cm_in, xover_r);
    pmh_nxt  = esc(ctrl_r[CSSC_B_PM_HI], ctrl_r[CSSC_B_PM_LAT], ctrl_r[CSSC_B_PM_FULL],
                   pm_in, xover_r);
    // lock is sticky until disabled; the release wins over a new error
    lock_nxt = ctrl_r[CSSC_B_LOCK] & (lock_r | mem_error);
    idle_nxt = pseudo_reset & ~ctrl_r[CSSC_B_NOABORT];
    err_nxt  = ctrl_r[CSSC_B_ERRHOLD] ? err_r : err_status_in;
    ev_nxt   = ctrl_r[CSSC_B_EVHOLD] ? ev_r : event_status_in;
    aack_nxt = hang_detect & ctrl_r[CSSC_B_AUTOACK];
    irq_nxt.dma_crit = dma_vm_err & ~ctrl_r[CSSC_B_DMASEV];
    irq_nxt.dma_norm = dma_vm_err & ctrl_r[CSSC_B_DMASEV];
    irq_nxt.dc_crit  = dc_vm_err & ~ctrl_r[CSSC_B_DCSEV];
    irq_nxt.dc_norm  = dc_vm_err & ctrl_r[CSSC_B_DCSEV];
    irq_nxt.lk_crit  = mem_locked & ~ctrl_r[CSSC_B_LKSEV];
    irq_nxt.lk_norm  = mem_locked & ctrl_r[CSSC_B_LKSEV];
    irq_nxt.srx_crit = serial_rx_irq & ctrl_r[CSSC_B_SRXCRIT];
    irq_nxt.srx_norm = serial_rx_irq & ~ctrl_r[CSSC_B_SRXCRIT];
  end

  // registers; synchronous active-low reset
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_r   <= CSSC_CTRL_RST;
      xover_r  <= CSSC_XOVER_RST[XW-1:0];
      err_r    <= 8'h00;
      ev_r     <= 8'h00;
      upper_r  <= 32'h0000_0000;
      half_r   <= 1'b0;
      wait_r   <= 1'b1;
      rd_r     <= 32'h0000_0000;
      lock_r   <= 1'b0;
      cmh_r    <= 1'b0;
      pmh_r    <= 1'b0;
      idle_r   <= 1'b0;
      aack_r   <= 1'b0;
      launch_r <= 1'b0;
      pdata_r  <= 64'h0;
      irq_r    <= '0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      xover_r  <= xover_nxt;
      err_r    <= err_nxt;
      ev_r     <= ev_nxt;
      upper_r  <= upper_nxt;
      half_r   <= half_nxt;
      wait_r   <= wait_nxt;
      rd_r     <= rd_nxt;
      lock_r   <= lock_nxt;
      cmh_r    <= cmh_nxt;
      pmh_r    <= pmh_nxt;
      idle_r   <= idle_nxt;
      aack_r   <= aack_nxt;
      launch_r <= launch_nxt;
      pdata_r  <= pdata_nxt;
      irq_r    <= irq_nxt;
    end
  end

  // outputs straight from flip-flops
  assign avs_readdata    = rd_r;
  assign avs_waitrequest = wait_r;
  assign cm_high_pri     = cmh_r;
  assign pm_high_pri     = pmh_r;
  assign arb_lock        = lock_r;
  assign pci_wbuf_bypass = ctrl_r[CSSC_B_PCI_BYP];
  assign pm_wbuf_bypass  = ctrl_r[CSSC_B_PM_BYP];
  assign cm_wbuf_bypass  = ctrl_r[CSSC_B_CM_BYP];
  assign master_idle     = idle_r;
  assign event_status    = ev_r;
  assign auto_ack        = aack_r;
  assign deadman_disable = ctrl_r[CSSC_B_DMDIS];
  assign irq_out         = irq_r;
  assign prim_launch     = launch_r;
  assign prim_data       = pdata_r;
endmodule

// ---- common/cssc_pkg.sv ----
// Purpose: shared constants and carriers for the subsystem control bits block
// Assumes: one clock, Avalon-MM register access, 32-bit data
// Notes:   bit positions are those of the subsystem control register
// Contract
// - bit26 escalates control memory on latency crossover
// - bit25 escalates control memory on write buffer full
// - bit24 makes control memory always high priority
// - bit23 escalates packet memory on latency crossover
// - bit22 escalates packet memory on write buffer full
// - bit21 makes packet memory always high priority
// - bit20 locks arbiter when an error occurs
// - bit19 bypasses PCI master write buffer
// - bit18 bypasses packet memory write buffer
// - bit17 set disables control memory write buffer
// - bit15 clear lets pseudo reset idle masters
// - bit14 set holds test-port error status
// - bit13 set holds core event status
// - bit12 set enables auto acknowledge on hang
// - bit11 picks DMA write error severity
// - bit10 picks data cache write error severity
// - bit9 picks memory-locked interrupt severity
// - bit8 makes primitives 64-bit, upper first
// - 64-bit primitive launches on second access only
// - bit7 disables all dead-man timers
// - bit6 makes serial receive interrupt critical
package cssc_pkg;
  // register byte offsets
  localparam logic [3:0]  CSSC_OFS_CTRL      = 4'h0;  // control word
  localparam logic [3:0]  CSSC_OFS_XOVER     = 4'h4;  // latency crossover value
  localparam logic [3:0]  CSSC_OFS_STATUS    = 4'h8;  // held status, read only
  localparam logic [3:0]  CSSC_OFS_PRIM      = 4'hc;  // primitive data window
  // control field positions
  localparam int CSSC_B_CM_LAT  = 26;
  localparam int CSSC_B_CM_FULL = 25;
  localparam int CSSC_B_CM_HI   = 24;
  localparam int CSSC_B_PM_LAT  = 23;
  localparam int CSSC_B_PM_FULL = 22;
  localparam int CSSC_B_PM_HI   = 21;
  localparam int CSSC_B_LOCK    = 20;
  localparam int CSSC_B_PCI_BYP = 19;
  localparam int CSSC_B_PM_BYP  = 18;
  localparam int CSSC_B_CM_BYP  = 17;
  localparam int CSSC_B_NOABORT = 15;
  localparam int CSSC_B_ERRHOLD = 14;
  localparam int CSSC_B_EVHOLD  = 13;
  localparam int CSSC_B_AUTOACK = 12;
  localparam int CSSC_B_DMASEV  = 11;
  localparam int CSSC_B_DCSEV   = 10;
  localparam int CSSC_B_LKSEV   = 9;
  localparam int CSSC_B_PRIM64  = 8;
  localparam int CSSC_B_DMDIS   = 7;
  localparam int CSSC_B_SRXCRIT = 6;
  // writable field mask: bits 26..17 and 15..6
  localparam logic [31:0] CSSC_CTRL_MASK     = 32'h07fe_ffc0;
  // reset value of the field bits
  localparam logic [31:0] CSSC_CTRL_RST      = 32'h000e_4000;
  localparam logic [15:0] CSSC_XOVER_RST     = 16'h0100;
  localparam logic [31:0] CSSC_UNMAPPED_DATA = 32'h0000_0000;

  // escalation inputs of one memory
  typedef struct packed {
    logic [15:0] lat_cnt;   // latency counter
    logic        wbuf_full; // write-around buffer full
    logic        req;       // request pending
  } cssc_mem_type;

  // interrupt routing outputs
  typedef struct packed {
    logic dma_crit;
    logic dma_norm;
    logic dc_crit;
    logic dc_norm;
    logic lk_crit;
    logic lk_norm;
    logic srx_crit;
    logic srx_norm;
  } cssc_irq_type;
endpackage

// ---- sim/cssc_ctrl_asserts.sv ----
// Purpose: port-level checks of the subsystem control block
// Assumes: all byte lanes written; shadow copy mirrors the control word
// Notes:   outputs are compared one clock after their causes
`timescale 1ns/1ns
module cssc_ctrl_chk
  import cssc_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         rst_b,
  input wire logic [3:0]   avs_address,
  input wire logic         avs_read,
  input wire logic         avs_write,
  input wire logic [31:0]  avs_writedata,
  input wire logic         avs_waitrequest,
  input wire cssc_mem_type cm_in,
  input wire cssc_mem_type pm_in,
  input wire logic         cm_high_pri,
  input wire logic         pm_high_pri,
  input wire logic         mem_error,
  input wire logic         arb_lock,
  input wire logic         pci_wbuf_bypass,
  input wire logic         pm_wbuf_bypass,
  input wire logic         cm_wbuf_bypass,
  input wire logic         pseudo_reset,
  input wire logic         master_idle,
  input wire logic [7:0]   event_status_in,
  input wire logic [7:0]   event_status,
  input wire logic         hang_detect,
  input wire logic         auto_ack,
  input wire logic         deadman_disable,
  input wire logic         dma_vm_err,
  input wire logic         dc_vm_err,
  input wire logic         mem_locked,
  input wire logic         serial_rx_irq,
  input wire cssc_irq_type irq_out,
  input wire logic         prim_launch
);
  logic [31:0] s_r, s_nxt;  // shadow of the control word
  logic [15:0] x_r, x_nxt;  // shadow of the crossover value
  wire         wr_done = avs_write && !avs_waitrequest;
  wire  [7:0]  irq_exp = {dma_vm_err & ~s_r[11], dma_vm_err & s_r[11], dc_vm_err & ~s_r[10],
    dc_vm_err & s_r[10], mem_locked & ~s_r[9], mem_locked & s_r[9],
    serial_rx_irq & s_r[6], serial_rx_irq & ~s_r[6]};
  // expected escalation; b is {latency, full, always}
  function automatic logic pri(cssc_mem_type m, logic [2:0] b, logic [15:0] xv);
    return m.req & (b[0] | (b[2] & (m.lat_cnt > xv)) | (b[1] & m.wbuf_full));
  endfunction
  // shadow follows completed writes only, so stalled requests never count
  always_comb begin
    s_nxt = s_r;
    x_nxt = x_r;
    if (wr_done && avs_address == CSSC_OFS_CTRL) s_nxt = avs_writedata & CSSC_CTRL_MASK;
    if (wr_done && avs_address == CSSC_OFS_XOVER) x_nxt = avs_writedata[15:0];
  end
  always_ff @(posedge clk_sys) begin
    s_r <= rst_b ? s_nxt : CSSC_CTRL_RST;
    x_r <= rst_b ? x_nxt : CSSC_XOVER_RST;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence req_seen;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence one_wait;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  AST_BUS: assert property (req_seen |=> one_wait) else $error("bus answer timing wrong");
  AST_CM_PRI: assert property ($past(rst_b) |-> cm_high_pri == $past(pri(cm_in, s_r[26:24], x_r)))
    else $error("control memory priority wrong");
  AST_PM_PRI: assert property ($past(rst_b) |-> pm_high_pri == $past(pri(pm_in, s_r[23:21], x_r)))
    else $error("packet memory priority wrong");
  AST_BYP: assert property ($past(rst_b) && $stable(s_r) |-> {pci_wbuf_bypass, pm_wbuf_bypass,
    cm_wbuf_bypass, deadman_disable} == {s_r[19:17], s_r[7]}) else $error("bypass bits wrong");
  AST_IDLE: assert property ($past(rst_b) |-> master_idle == $past(pseudo_reset & ~s_r[15]))
    else $error("master idle wrong");
  AST_ACK: assert property ($past(rst_b) |-> auto_ack == $past(hang_detect & s_r[12]))
    else $error("auto ack wrong");
  AST_EV: assert property ($past(rst_b) |-> event_status == ($past(s_r[13]) ? $past(event_status)
    : $past(event_status_in))) else $error("event status wrong");
  AST_IRQ: assert property ($past(rst_b) |-> irq_out == $past(irq_exp))
    else $error("interrupt routing wrong");
  AST_LOCK: assert property ($past(rst_b) && $past(mem_error && s_r[20]) |-> arb_lock)
    else $error("lock not raised");
  AST_UNLOCK: assert property ($past(rst_b) && !$past(s_r[20]) |-> !arb_lock)
    else $error("lock without enable");
  AST_PRIM: assert property (prim_launch |-> $past(wr_done && avs_address == CSSC_OFS_PRIM))
    else $error("launch without write");
endmodule

// ---- sim/cssc_mem_model.sv ----
// Purpose: memory side model feeding the escalation inputs
// Assumes: latency counts every cycle a request waits
// Notes:   counter clears when the request is withdrawn
`timescale 1ns/1ns
module cssc_mem_model
  import cssc_pkg::*;
(
  input  wire logic [1:0] req,   // {packet, control}
  input  wire logic [1:0] full,  // {packet, control}
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  output cssc_mem_type    cm_o,
  output cssc_mem_type    pm_o
);
  // registered so that the model changes only just after an edge
  always_ff @(posedge clk_sys) begin
    cm_o.req       <= rst_b & req[0];
    pm_o.req       <= rst_b & req[1];
    cm_o.wbuf_full <= rst_b & full[0];
    pm_o.wbuf_full <= rst_b & full[1];
    cm_o.lat_cnt   <= (rst_b & req[0]) ? cm_o.lat_cnt + 16'h1 : 16'h0;
    pm_o.lat_cnt   <= (rst_b & req[1]) ? pm_o.lat_cnt + 16'h1 : 16'h0;
  end
endmodule

// ---- sim/tb_cssc_ctrl.sv ----
// Purpose: register-driven scenarios for the subsystem control block
// Assumes: outputs are read two edges after the inputs change
// Notes:   escalation inputs come through the memory model
`timescale 1ns/1ns
module tb_cssc_ctrl;
  import cssc_pkg::*;
  logic clk_sys = 0, rst_b = 0, avs_read = 0, avs_write = 0, mem_error = 0;
  logic pseudo_reset = 0, hang_detect = 0, dma_vm_err = 0, dc_vm_err = 0;
  logic mem_locked = 0, serial_rx_irq = 0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [7:0] err_status_in = 8'h0, event_status_in = 8'h0, event_status;
  logic [1:0] req = 2'h0, full = 2'h0;
  logic avs_waitrequest, cm_high_pri, pm_high_pri, arb_lock, pci_wbuf_bypass, pm_wbuf_bypass;
  logic cm_wbuf_bypass, master_idle, auto_ack, deadman_disable, prim_launch;
  logic [63:0] prim_data, last;
  cssc_mem_type cm_in, pm_in;
  cssc_irq_type irq_out;
  int miscompares = 0, n_tests = 0, n_launch = 0;
  cssc_ctrl cssc_ctrl_inst (.*);
  cssc_mem_model cssc_mem_model_inst (.req(req), .full(full), .clk_sys(clk_sys),
    .rst_b(rst_b), .cm_o(cm_in), .pm_o(pm_in));
  initial forever #4 clk_sys = ~clk_sys;
  // launches are pulses, so they are counted as they pass
  always @(posedge clk_sys) if (prim_launch === 1'b1) begin
    n_launch++;
    last = prim_data;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one avalon cycle; a released edge follows so strobes never retoggle in one step
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 50) begin
      miscompares++;
      final_report();
    end
    @(posedge clk_sys);
  endtask
  initial begin
    tick(20);
    rst_b <= 1'b1;
    tick(1);
    bus(0, CSSC_OFS_CTRL, 0); chk(rd, CSSC_CTRL_RST);
    chk({pci_wbuf_bypass, pm_wbuf_bypass, cm_wbuf_bypass}, 3'h7);
    bus(0, CSSC_OFS_XOVER, 0); chk(rd, {16'h0, CSSC_XOVER_RST});
    bus(0, 4'h2, 0); chk(rd, CSSC_UNMAPPED_DATA);
    bus(1, CSSC_OFS_CTRL, 32'hffff_ffff);
    bus(0, CSSC_OFS_CTRL, 0); chk(rd, CSSC_CTRL_MASK);
    chk({pci_wbuf_bypass, pm_wbuf_bypass, cm_wbuf_bypass, deadman_disable}, 4'hf);
    bus(1, CSSC_OFS_XOVER, 32'h5);
    for (int m = 0; m < 2; m++) for (int k = 0; k < 3; k++) begin
      bus(1, CSSC_OFS_CTRL, 32'h1 << (CSSC_B_CM_LAT - 3 * m - k));
      req <= 2'h1 << m;
      full <= 2'h3;
      tick(3); chk(m ? pm_high_pri : cm_high_pri, k != 0);
      tick(7); chk(m ? pm_high_pri : cm_high_pri, 1'b1);
      req <= 2'h0;
      tick(3); chk(m ? pm_high_pri : cm_high_pri, 1'b0);
    end
    bus(1, CSSC_OFS_CTRL, 32'h1 << CSSC_B_LOCK);
    mem_error <= 1'b1;
    tick(1);
    mem_error <= 1'b0;
    tick(3); chk(arb_lock, 1'b1);
    bus(1, CSSC_OFS_CTRL, 0); tick(1); chk(arb_lock, 1'b0);
    for (int v = 0; v < 2; v++) begin
      bus(1, CSSC_OFS_CTRL, v ? 32'h0000_fe00 : 32'h40);
      pseudo_reset <= 1'b1;
      hang_detect <= 1'b1;
      {dma_vm_err, dc_vm_err, mem_locked, serial_rx_irq} <= 4'hf;
      event_status_in <= v ? 8'hc3 : 8'h3c;
      err_status_in <= v ? 8'h12 : 8'h21;
      tick(2); chk(master_idle, !v);
      chk(auto_ack, v);
      chk(event_status, 8'h3c);
      chk(irq_out, v ? 8'h55 : 8'haa);
      bus(0, CSSC_OFS_STATUS, 0); chk(rd[23:8], 16'h3c21);
    end
    bus(1, CSSC_OFS_CTRL, 32'h1 << CSSC_B_PRIM64);
    bus(1, CSSC_OFS_PRIM, 32'hcafe_0001);
    tick(2); chk(n_launch, 0);
    bus(1, CSSC_OFS_PRIM, 32'hbeef_0002);
    tick(2); chk(n_launch, 1);
    chk(last, 64'hcafe_0001_beef_0002);
    bus(1, CSSC_OFS_CTRL, 0);
    bus(1, CSSC_OFS_PRIM, 32'h1234_5678);
    tick(2); chk(n_launch, 2);
    chk(last, 64'h1234_5678);
    final_report();
  end
endmodule
bind cssc_ctrl cssc_ctrl_chk cssc_ctrl_chk_inst (.*);
